// ### rtcac_pkg.sv
package rtcac_pkg;

  // Bus geometry: byte address, one 32-bit word per register
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_ALARM_HOUR = 8'hEA;
  localparam logic [7:0] IDX_ALARM_WEEKDAY = 8'hEB;
  localparam logic [7:0] IDX_ALARM_ENABLES = 8'hEC;
  localparam logic [7:0] IDX_CLOCK_CTRL = 8'hED;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_HOUR = {IDX_ALARM_HOUR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ALARM_WEEKDAY = {IDX_ALARM_WEEKDAY, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ALARM_ENABLES = {IDX_ALARM_ENABLES, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CTRL = {IDX_CLOCK_CTRL, 2'b00};

  // Control and status bit positions
  localparam int CTRL_ALARM = 7;
  localparam int CTRL_INT_EN = 6;
  localparam int CTRL_BCD = 5;
  localparam int CTRL_CLK_SEL = 4;
  localparam int CTRL_LINE_FREQUENCY_SELECT = 3;
  localparam int CTRL_SUMMER = 2;
  localparam int CTRL_WOKE = 1;
  localparam int CTRL_UNLOCK = 0;

  // Alarm enable bit positions
  localparam int EN_WEEKDAY = 3;
  localparam int EN_HOUR = 2;
  localparam int EN_MINUTE = 1;
  localparam int EN_SECOND = 0;

  // Reset values of the bits that reset touches
  localparam logic [3:0] ENABLES_RESET = 4'h0;
  localparam logic INT_EN_RESET = 1'b0;
  localparam logic UNLOCK_RESET = 1'b0;

  // Prescale divisors for the three time bases
  localparam logic [15:0] DIV_CRYSTAL = 16'h8000;
  localparam logic [15:0] DIV_LINE_60HZ = 16'h003C;
  localparam logic [15:0] DIV_LINE_50HZ = 16'h0032;

  // Current time-count fields, as kept by the count registers
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtcac_time_type;

  // Settings passed to the counter, prescaler and oscillator
  typedef struct packed {
    logic bcd_mode;
    logic osc_enable;
    logic line_source;
    logic line_frequency_select;
    logic summer_time_select;
    logic count_unlock;
  } rtcac_ctrl_type;

endpackage : rtcac_pkg

// ### rtcac_alarm_ctrl.sv
// What this block does
// - Alarm hour set-point is always readable and writable, eight bits.
// - Reset leaves alarm hour and weekday set-points untouched.
// - Weekday set-point holds 1..7 in bits 3:0; bits 7:4 read zero.
// - Weekday writes ignored while locked; taken only while unlocked.
// - Reset clears alarm enables; bits 7:4 read zero, only 3:0 writable.
// - Enable bits: 3 weekday, 2 hour, 1 minute, 0 second.
// - Reading control register clears alarm flag and its interrupt.
// - Alarm flag evaluated only on relock or on a count increment.
// - Every control register write resets the time-base prescaler.
// - Sleep-wake bit marks alarm wake, survives that reset, read clears.
// - Bit 5 selects BCD coding for count and alarm registers.
// - Bit 4 low: crystal on, divide by 32768; high: line input.
// - Bit 3 picks line prescale: zero 60 Hz, one 50 Hz.
// - Interrupt follows alarm flag only when bit 6 set; reset clears it.
// - Bit 2 is a writable summer-time choice kept across reset.
// - Unlock bit opens count writes and halts count; reset clears it.
// - Reset clears bits 6 and 0, loads wake cause, keeps the rest.
// - Alarm seconds set-point 00h..3Bh or BCD 0-5/0-9, held outside.
// - Alarm minutes set-point up to 3Bh or BCD 0-5/0-9, held outside.
// - Time-count registers writable only while unlocked.
`timescale 1ns/1ps

module rtcac_alarm_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Avalon-MM register slave
  input wire logic [rtcac_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rtcac_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [rtcac_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Time-count side
  input wire rtcac_pkg::rtcac_time_type cur_time,
  input wire logic count_increment,
  input wire logic [7:0] alarm_second_value,
  input wire logic [7:0] alarm_minute_value,
  output rtcac_pkg::rtcac_ctrl_type ctrl_out,
  // Prescaler side
  output logic prescaler_reset,
  output logic [15:0] prescale_divisor,
  // Power management and interrupt
  input wire logic wake_cause_alarm,
  output logic alarm_wake_request,
  output logic irq
);

  // Stored state
  logic ack_ff;
  logic [rtcac_pkg::DATA_W-1:0] readdata_ff;
  logic [7:0] alarm_hour_ff;
  logic [3:0] alarm_weekday_ff;
  logic [3:0] enables_ff;
  logic alarm_flag_ff;
  logic int_en_ff;
  logic bcd_ff;
  logic clk_sel_ff;
  logic line_frequency_select_ff;
  logic summer_ff;
  logic woke_ff;
  logic unlock_ff;
  logic relock_ff;
  logic presc_reset_ff;
  logic [15:0] divisor_ff;
  logic wake_req_ff;

  // Bus handshake: one wait cycle, then the access completes
  wire req = avs_read | avs_write;
  wire accept = req & ack_ff;
  wire nxt_ack = req & ~ack_ff;
  assign avs_waitrequest = req & ~ack_ff;

  // Address decode
  wire hit_hour = avs_address == rtcac_pkg::ADDR_ALARM_HOUR;
  wire hit_weekday = avs_address == rtcac_pkg::ADDR_ALARM_WEEKDAY;
  wire hit_enables = avs_address == rtcac_pkg::ADDR_ALARM_ENABLES;
  wire hit_ctrl = avs_address == rtcac_pkg::ADDR_CLOCK_CTRL;

  // Write strobes; only byte lane 0 carries register data
  wire wr_low = accept & avs_write & avs_byteenable[0];
  wire [7:0] wdata = avs_writedata[7:0];
  wire wr_hour = wr_low & hit_hour;
  wire wr_weekday = wr_low & hit_weekday & unlock_ff;
  wire wr_enables = wr_low & hit_enables;
  wire wr_ctrl = wr_low & hit_ctrl;
  wire rd_ctrl = accept & avs_read & hit_ctrl;

  // Control register image as software sees it
  wire [7:0] ctrl_image = {alarm_flag_ff, int_en_ff, bcd_ff, clk_sel_ff,
                           line_frequency_select_ff, summer_ff, woke_ff, unlock_ff};

  // Read mux; unmapped addresses read as zero
  wire [7:0] rd_byte = hit_hour ? alarm_hour_ff :
                       hit_weekday ? {4'h0, alarm_weekday_ff} :
                       hit_enables ? {4'h0, enables_ff} :
                       hit_ctrl ? ctrl_image : 8'h00;
  wire [rtcac_pkg::DATA_W-1:0] nxt_readdata = nxt_ack ?
                                              {24'h000000, rd_byte} : readdata_ff;

  // Field comparison; both sides share one coding so equality serves binary and BCD
  wire [3:0] field_eq;
  assign field_eq[rtcac_pkg::EN_WEEKDAY] = cur_time.weekday == {4'h0, alarm_weekday_ff};
  assign field_eq[rtcac_pkg::EN_HOUR] = cur_time.hour == alarm_hour_ff;
  assign field_eq[rtcac_pkg::EN_MINUTE] = cur_time.minute == alarm_minute_value;
  assign field_eq[rtcac_pkg::EN_SECOND] = cur_time.second == alarm_second_value;
  wire match = (|enables_ff) & (&(field_eq | ~enables_ff));

  // Flag is judged only at these two moments, never on a plain write
  wire eval_now = count_increment | relock_ff;
  // Evaluation wins over a read clear in the same cycle
  wire nxt_alarm_flag = eval_now ? match : (rd_ctrl ? 1'b0 : alarm_flag_ff);

  // Relock is a write that drops the unlock bit
  wire nxt_relock = wr_ctrl & unlock_ff & ~wdata[rtcac_pkg::CTRL_UNLOCK];

  // Prescale value follows the source and line frequency
  wire [15:0] nxt_divisor = ~clk_sel_ff ? rtcac_pkg::DIV_CRYSTAL :
                            line_frequency_select_ff ? rtcac_pkg::DIV_LINE_50HZ :
                            rtcac_pkg::DIV_LINE_60HZ;

  // Handshake and read data
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_ff <= 1'b0;
      readdata_ff <= '0;
    end else begin
      ack_ff <= nxt_ack;
      readdata_ff <= nxt_readdata;
    end
  end

  // Set-points and kept control bits have no reset: they hold across it
  always_ff @(posedge clock) begin
    if (wr_hour) begin
      alarm_hour_ff <= wdata;
    end
    if (wr_weekday) begin
      alarm_weekday_ff <= wdata[3:0];
    end
    if (wr_ctrl && !srst) begin
      bcd_ff <= wdata[rtcac_pkg::CTRL_BCD];
      clk_sel_ff <= wdata[rtcac_pkg::CTRL_CLK_SEL];
      line_frequency_select_ff <= wdata[rtcac_pkg::CTRL_LINE_FREQUENCY_SELECT];
      summer_ff <= wdata[rtcac_pkg::CTRL_SUMMER];
    end
    alarm_flag_ff <= srst ? alarm_flag_ff : nxt_alarm_flag;
    divisor_ff <= nxt_divisor;
  end

  // Alarm enables
  always_ff @(posedge clock) begin
    if (srst) begin
      enables_ff <= rtcac_pkg::ENABLES_RESET;
    end else if (wr_enables) begin
      enables_ff <= wdata[3:0];
    end
  end

  // Control bits that reset clears
  always_ff @(posedge clock) begin
    if (srst) begin
      int_en_ff <= rtcac_pkg::INT_EN_RESET;
      unlock_ff <= rtcac_pkg::UNLOCK_RESET;
    end else if (wr_ctrl) begin
      int_en_ff <= wdata[rtcac_pkg::CTRL_INT_EN];
      unlock_ff <= wdata[rtcac_pkg::CTRL_UNLOCK];
    end
  end

  // Sleep-wake bit loads the wake cause during reset, so a wake reset keeps it
  always_ff @(posedge clock) begin
    if (srst) begin
      woke_ff <= wake_cause_alarm;
    end else if (rd_ctrl) begin
      woke_ff <= 1'b0;
    end
  end

  // Event pulses
  always_ff @(posedge clock) begin
    if (srst) begin
      relock_ff <= 1'b0;
      presc_reset_ff <= 1'b0;
      wake_req_ff <= 1'b0;
    end else begin
      relock_ff <= nxt_relock;
      presc_reset_ff <= wr_ctrl;
      wake_req_ff <= eval_now & match;
    end
  end

  // Outputs; count registers outside use count_unlock as their write gate
  assign avs_readdata = readdata_ff;
  assign prescaler_reset = presc_reset_ff;
  assign prescale_divisor = divisor_ff;
  assign alarm_wake_request = wake_req_ff;
  assign irq = alarm_flag_ff & int_en_ff;
  assign ctrl_out.bcd_mode = bcd_ff;
  assign ctrl_out.osc_enable = ~clk_sel_ff;
  assign ctrl_out.line_source = clk_sel_ff;
  assign ctrl_out.line_frequency_select = line_frequency_select_ff;
  assign ctrl_out.summer_time_select = summer_ff;
  assign ctrl_out.count_unlock = unlock_ff;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_wait_one_cycle: assert property (
    avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

  a_weekday_locked: assert property (
    (wr_low && hit_weekday && !unlock_ff) |=> alarm_weekday_ff == $past(alarm_weekday_ff))
    else $error("weekday set-point changed while locked");

  a_upper_zero: assert property (
    (accept && avs_read && (hit_weekday || hit_enables)) |-> avs_readdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  a_flag_eval: assert property (
    eval_now |=> alarm_flag_ff == $past(match))
    else $error("alarm flag not equal to match after evaluation");

  a_flag_hold: assert property (
    (!eval_now && !rd_ctrl) |=> $stable(alarm_flag_ff))
    else $error("alarm flag moved outside evaluation");

  a_flag_read_clear: assert property (
    (rd_ctrl && !eval_now) |=> !alarm_flag_ff && !irq)
    else $error("control read did not clear alarm");

  a_irq_gated: assert property (
    !int_en_ff |-> !irq)
    else $error("interrupt without enable");

  a_presc_pulse: assert property (
    wr_ctrl |=> prescaler_reset ##1 (!prescaler_reset || $past(wr_ctrl)))
    else $error("prescaler reset not a pulse after control write");

  a_crystal_div: assert property (
    (wr_ctrl && !wdata[rtcac_pkg::CTRL_CLK_SEL]) |-> ##2 prescale_divisor == 16'h8000)
    else $error("crystal divisor wrong");

  a_line_div: assert property (
    (wr_ctrl && wdata[rtcac_pkg::CTRL_CLK_SEL] && wdata[rtcac_pkg::CTRL_LINE_FREQUENCY_SELECT])
    |-> ##2 prescale_divisor == 16'h0032)
    else $error("50 Hz divisor wrong");

  a_relock_eval: assert property (
    nxt_relock |=> eval_now ##1 alarm_flag_ff == $past(match))
    else $error("relock did not evaluate alarm");

  a_woke_clear: assert property (
    rd_ctrl |=> !woke_ff)
    else $error("sleep-wake bit not cleared by read");

  a_wake_request: assert property (
    (eval_now && match) |=> alarm_wake_request)
    else $error("no wake request on alarm");

  a_reset_clear: assert property (
    @(posedge clock) disable iff (1'b0)
    srst |=> !int_en_ff && !unlock_ff && enables_ff == 4'h0 && woke_ff == $past(wake_cause_alarm))
    else $error("reset values wrong");

  // Register write and field checks; write checks look one cycle after the completing edge, a_line_60 two cycles after

  a_hour_write: assert property (
    wr_hour |=> alarm_hour_ff == $past(wdata))
    else $error("hour set-point did not take write");

  a_weekday_write: assert property (
    wr_weekday |=> alarm_weekday_ff == $past(wdata[3:0]))
    else $error("weekday set-point did not take write");

  a_enables_write: assert property (
    wr_enables |=> enables_ff == $past(wdata[3:0]))
    else $error("alarm enables did not take write");

  a_enables_reset: assert property (
    @(posedge clock) disable iff (1'b0)
    srst |=> enables_ff == 4'h0)
    else $error("alarm enables not cleared by reset");

  a_unlock_reset: assert property (
    @(posedge clock) disable iff (1'b0)
    srst |=> !ctrl_out.count_unlock)
    else $error("unlock bit not cleared by reset");

  a_bcd_write: assert property (
    wr_ctrl |=> ctrl_out.bcd_mode == $past(wdata[rtcac_pkg::CTRL_BCD]))
    else $error("coding select did not follow write");

  a_summer_write: assert property (
    wr_ctrl |=> ctrl_out.summer_time_select == $past(wdata[rtcac_pkg::CTRL_SUMMER]))
    else $error("summer-time select did not follow write");

  a_unlock_write: assert property (
    wr_ctrl |=> ctrl_out.count_unlock == $past(wdata[rtcac_pkg::CTRL_UNLOCK]))
    else $error("unlock bit did not follow write");

  a_osc_write: assert property (
    wr_ctrl |=> ctrl_out.osc_enable == !$past(wdata[rtcac_pkg::CTRL_CLK_SEL]))
    else $error("oscillator enable wrong after write");

  a_line_60: assert property (
    (wr_ctrl && wdata[rtcac_pkg::CTRL_CLK_SEL] && !wdata[rtcac_pkg::CTRL_LINE_FREQUENCY_SELECT])
    |-> ##2 prescale_divisor == 16'h003C)
    else $error("60 Hz divisor wrong");

  a_woke_readonly: assert property (
    wr_ctrl |=> woke_ff == $past(woke_ff))
    else $error("sleep-wake bit changed by a write");

  a_flag_readonly: assert property (
    (wr_ctrl && !eval_now) |=> alarm_flag_ff == $past(alarm_flag_ff))
    else $error("alarm flag changed by a write");

  a_no_enable: assert property (
    enables_ff == 4'h0 |-> !match)
    else $error("match with no field enabled");

  a_irq_follow: assert property (
    int_en_ff |-> irq == alarm_flag_ff)
    else $error("interrupt does not follow alarm flag");

  a_readdata_upper: assert property (
    accept |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bytes nonzero");

  a_relock_source: assert property (
    relock_ff |-> $past(wr_ctrl))
    else $error("relock evaluation without control write");

  a_presc_source: assert property (
    prescaler_reset |-> $past(wr_ctrl))
    else $error("prescaler reset without control write");

  // Main scenarios
  c_alarm_irq: cover property (count_increment && match && int_en_ff ##1 irq);
  c_read_clear: cover property (alarm_flag_ff ##1 rd_ctrl ##1 !alarm_flag_ff);
  c_relock: cover property (nxt_relock ##2 alarm_flag_ff);
  c_locked_write: cover property (wr_low && hit_weekday && !unlock_ff);

endmodule : rtcac_alarm_ctrl

// ### rtcac_alarm_ctrl_tb_top.sv
`timescale 1ns/1ps

module rtcac_alarm_ctrl_tb_top;
  // Register addresses
  localparam logic [9:0] A_HR = rtcac_pkg::ADDR_ALARM_HOUR;
  localparam logic [9:0] A_WD = rtcac_pkg::ADDR_ALARM_WEEKDAY;
  localparam logic [9:0] A_EN = rtcac_pkg::ADDR_ALARM_ENABLES;
  localparam logic [9:0] A_CT = rtcac_pkg::ADDR_CLOCK_CTRL;
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  rtcac_pkg::rtcac_time_type cur_time = '0;
  logic count_increment = 1'b0;
  logic [7:0] alarm_second_value = 8'h00;
  logic [7:0] alarm_minute_value = 8'h00;
  rtcac_pkg::rtcac_ctrl_type ctrl_out;
  logic prescaler_reset;
  logic [15:0] prescale_divisor;
  logic wake_cause_alarm = 1'b1;
  logic alarm_wake_request;
  logic irq;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] rdw;
  logic [7:0] cv [3] = '{8'h20, 8'h10, 8'h1C};
  logic [15:0] dv [3] = '{16'h8000, 16'h003C, 16'h0032};
  logic [5:0] ov [3] = '{6'h30, 6'h08, 6'h0E};

  rtcac_alarm_ctrl rtcac_alarm_ctrl_inst (
    .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cur_time(cur_time),
    .count_increment(count_increment), .alarm_second_value(alarm_second_value),
    .alarm_minute_value(alarm_minute_value), .ctrl_out(ctrl_out),
    .prescaler_reset(prescaler_reset), .prescale_divisor(prescale_divisor),
    .wake_cause_alarm(wake_cause_alarm), .alarm_wake_request(alarm_wake_request), .irq(irq)
  );

  // Free-running 50 MHz clock
  initial forever #10 clock = ~clock;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // One bus access; held until waitrequest is seen low, idle cycle before the next
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    @(negedge clock);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        fail_count++;
        wrap_up();
      end
      @(negedge clock);
    end
    rdw = avs_readdata;
    @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Single count increment pulse, then look half a cycle after it ends
  task automatic inc;
    @(posedge clock);
    count_increment <= 1'b1;
    @(posedge clock);
    count_increment <= 1'b0;
    @(negedge clock);
  endtask : inc

  task automatic t_reset;
    bus(1'b0, A_EN, 8'h00); chk(rdw, 32'h0);
    bus(1'b0, A_CT, 8'h00); chk({rdw[6], rdw[1:0]}, 3'b010);
    bus(1'b0, A_CT, 8'h00); chk(rdw[1], 1'b0);
    chk(irq, 1'b0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_regs;
    bus(1'b1, A_CT, 8'h01);
    bus(1'b1, A_HR, 8'h17); bus(1'b0, A_HR, 8'h00); chk(rdw, 32'h17);
    // A write with no byte lane enabled must leave the register alone
    avs_byteenable <= 4'h0;
    bus(1'b1, A_HR, 8'h05);
    avs_byteenable <= 4'hF;
    bus(1'b0, A_HR, 8'h00); chk(rdw, 32'h17);
    bus(1'b1, A_WD, 8'hF5); bus(1'b0, A_WD, 8'h00); chk(rdw, 32'h05);
    bus(1'b1, A_EN, 8'hFF); bus(1'b0, A_EN, 8'h00); chk(rdw, 32'h0F);
    bus(1'b1, A_CT, 8'h00);
    bus(1'b1, A_WD, 8'h03); bus(1'b0, A_WD, 8'h00); chk(rdw, 32'h05);
    bus(1'b0, 10'h3FC, 8'h00); chk(rdw, 32'h0);
    $display("register test done");
  endtask : t_regs

  task automatic t_ctrl;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, A_CT, cv[i]);
      @(negedge clock); chk(prescaler_reset, 1'b1);
      @(negedge clock); chk(prescale_divisor, dv[i]);
      chk(prescaler_reset, 1'b0);
      chk(ctrl_out, ov[i]);
      bus(1'b0, A_CT, 8'h00); chk(rdw[5:2], cv[i][5:2]);
    end
    $display("control test done");
  endtask : t_ctrl

  task automatic t_alarm;
    logic w;
    bus(1'b1, A_CT, 8'h44);
    bus(1'b1, A_EN, 8'h04);
    cur_time.hour <= 8'h17;
    inc(); chk(irq, 1'b1);
    w = alarm_wake_request;
    @(negedge clock); w = w | alarm_wake_request; chk(w, 1'b1);
    // Count moves away with no increment: flag must hold
    cur_time.hour <= 8'h10;
    repeat (3) @(negedge clock);
    chk(irq, 1'b1);
    bus(1'b0, A_CT, 8'h00); chk(rdw[7], 1'b1);
    @(negedge clock); chk(irq, 1'b0);
    cur_time.hour <= 8'h17;
    bus(1'b1, A_EN, 8'h00);
    inc(); chk(irq, 1'b0);
    bus(1'b1, A_EN, 8'h0C);
    inc(); chk(irq, 1'b0);
    bus(1'b1, A_CT, 8'h04);
    bus(1'b1, A_EN, 8'h04);
    inc(); chk(irq, 1'b0);
    bus(1'b0, A_CT, 8'h00); chk(rdw[7], 1'b1);
    $display("alarm test done");
  endtask : t_alarm

  task automatic t_keep;
    @(posedge clock);
    wake_cause_alarm <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, A_HR, 8'h00); chk(rdw, 32'h17);
    bus(1'b0, A_WD, 8'h00); chk(rdw, 32'h05);
    bus(1'b0, A_CT, 8'h00); chk(rdw[6:0], 7'h04);
    $display("reset keep test done");
  endtask : t_keep

  // Main sequence: 12-cycle reset with an alarm wake cause present
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    wake_cause_alarm <= 1'b0;
    t_reset();
    t_regs();
    t_ctrl();
    t_alarm();
    t_keep();
    wrap_up();
  end
endmodule : rtcac_alarm_ctrl_tb_top
